// >>> rtl/sopla_map.svh
`ifndef SOPLA_MAP_SVH
`define SOPLA_MAP_SVH

`define SOPLA_NUM_OUT      8
`define SOPLA_NUM_IN       16
`define SOPLA_NUM_LIT      32
`define SOPLA_TERMS        8
`define SOPLA_ENABLE_TERM  7
`define SOPLA_REG_DED_IN   8
`define SOPLA_COMB_DED_IN  10
`define SOPLA_CLK_NS       50
`define SOPLA_POR_NS       1000
`define SOPLA_POR_CYC      (`SOPLA_POR_NS / `SOPLA_CLK_NS)
`define SOPLA_MASK_R8      8'hff
`define SOPLA_MASK_R6      8'h7e
`define SOPLA_MASK_R4      8'h3c
`define SOPLA_MASK_NONE    8'h00
`define SOPLA_ALL_OFF      8'hff
`define SOPLA_STATE_CLR    8'h00
`define SOPLA_SEC_ROW      32'hffff_ffff
`define SOPLA_ROW_CLR      32'h0000_0000

`endif

// >>> rtl/sopla_pkg.sv
package sopla_pkg;

    typedef logic [31:0] sopla_row_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oen;
    } sopla_pins_s;

    typedef enum logic [0:0] {
        SOPLA_HOLD = 1'b0,
        SOPLA_RUN  = 1'b1
    } sopla_por_e;

    function automatic logic sopla_term(input sopla_row_t conn, input sopla_row_t lits);
        sopla_term = &(~conn | lits);
    endfunction : sopla_term

endpackage : sopla_pkg

// >>> rtl/sopla_cell.sv
`timescale 1ns/1ps
`include "sopla_map.svh"

module sopla_cell
    import sopla_pkg::*;
#(
    parameter bit IS_REG = 1'b0
)
(
    // array rows of this output and shared literals
    input  wire sopla_row_t       rows [`SOPLA_TERMS],
    input  wire sopla_row_t       lits,
    // sum and enable
    output logic                  sum,
    output logic                  enable
);

    logic [`SOPLA_TERMS-1:0] hit;

    genvar t;
    generate
        for (t = 0; t < `SOPLA_TERMS; t++)
        begin : g_term
            assign hit[t] = sopla_term(rows[t], lits);
        end
    endgenerate

    always_comb
    begin
        if (IS_REG)
        begin
            sum    = |hit;
            enable = 1'b1;
        end
        else
        begin
            // last row steers the driver, so only seven rows feed the sum
            sum    = |hit[`SOPLA_ENABLE_TERM-1:0];
            enable = hit[`SOPLA_ENABLE_TERM];
        end
    end

endmodule : sopla_cell

// >>> rtl/sopla_top.sv
// Behaviour
// - registered outputs are D flip-flops loaded on the rising clock edge.
// - registered variants have eight dedicated inputs; combinational outputs are bidirectional.
// - combinational variant has ten inputs, eight outputs, six of them feeding back.
// - every array input is offered in true and inverted polarity.
// - each combinational driver is enabled by its own product term.
// - with its enable term false, a combinational pin is only an input, except the outer two pins of the combinational variant, which have no feedback.
// - one dedicated pin enables all registered drivers together.
// - preload mode loads each flip-flop from the value forced on its pin.
// - all flip-flops clear low at power-up within 1000 ns.
// - registered pins drive the inverse of the stored state.
// - with security set, readback returns all ones in place of every connection as programmed.
// - empty term is high; term with both polarities of an input is low.
// - each output is the OR of its terms, each an AND of literals.
`timescale 1ns/1ps
`include "sopla_map.svh"

module sopla_top
    import sopla_pkg::*;
#(
    parameter int NUM_REG = 8
)
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // dedicated inputs
    input  wire logic [9:0]       din,
    input  wire logic             reg_oe_n,
    // output pins
    input  wire logic [7:0]       pin_in,
    output logic      [7:0]       pin_out,
    output logic      [7:0]       pin_oen,
    // programmed array and options
    input  wire sopla_row_t       fuse_rows [`SOPLA_NUM_OUT*`SOPLA_TERMS],
    input  wire logic             secure,
    input  wire logic             preload,
    // pattern readback
    input  wire logic [5:0]       rb_addr,
    output sopla_row_t            rb_data
);

    localparam logic [7:0] REG_MASK = (NUM_REG == 8) ? `SOPLA_MASK_R8 :
                                      (NUM_REG == 6) ? `SOPLA_MASK_R6 :
                                      (NUM_REG == 4) ? `SOPLA_MASK_R4 : `SOPLA_MASK_NONE;
    localparam logic [4:0] POR_CYC  = 5'(`SOPLA_POR_CYC);

    logic [7:0]         state_q;
    logic [7:0]         state_d;
    sopla_pins_s        pins_q;
    sopla_pins_s        pins_d;
    sopla_row_t         rb_q;
    sopla_row_t         rb_d;
    sopla_por_e         por_q;
    sopla_por_e         por_d;
    logic [4:0]         por_cnt_q;
    logic [4:0]         por_cnt_d;

    logic [`SOPLA_NUM_IN-1:0]  arr_in;
    sopla_row_t                lits;
    logic [7:0]                sums;
    logic [7:0]                enables;

    // array inputs: dedicated lines then feedback
    always_comb
    begin
        if (NUM_REG == 0)
        begin
            // outer two outputs have no feedback path
            arr_in = {din[`SOPLA_COMB_DED_IN-1:0], pin_in[6:1]};
        end
        else
        begin
            arr_in[`SOPLA_REG_DED_IN-1:0] = din[`SOPLA_REG_DED_IN-1:0];
            for (int k = 0; k < `SOPLA_NUM_OUT; k++)
            begin
                // registered cells feed back state, others read their pin
                arr_in[`SOPLA_REG_DED_IN+k] = REG_MASK[k] ? state_q[k] : pin_in[k];
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < `SOPLA_NUM_IN; i++)
        begin : g_lit
            assign lits[2*i]   = arr_in[i];
            assign lits[2*i+1] = ~arr_in[i];
        end

        for (i = 0; i < `SOPLA_NUM_OUT; i++)
        begin : g_cell
            sopla_cell #(
                .IS_REG (REG_MASK[i])
            ) u_cell (
                .rows   (fuse_rows[i*`SOPLA_TERMS +: `SOPLA_TERMS]),
                .lits   (lits),
                .sum    (sums[i]),
                .enable (enables[i])
            );
        end
    endgenerate

    // power-up clear sequence
    always_comb
    begin
        por_d     = por_q;
        por_cnt_d = por_cnt_q;
        case (por_q)
            SOPLA_HOLD:
            begin
                // hold cleared for the full window, never longer
                if (por_cnt_q >= POR_CYC - 5'd1)
                begin
                    por_d = SOPLA_RUN;
                end
                else
                begin
                    por_cnt_d = por_cnt_q + 5'd1;
                end
            end
            SOPLA_RUN:
            begin
                por_d = SOPLA_RUN;
            end
            default:
            begin
                por_d = SOPLA_HOLD;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            por_q     <= SOPLA_HOLD;
            por_cnt_q <= 5'd0;
        end
        else
        begin
            por_q     <= por_d;
            por_cnt_q <= por_cnt_d;
        end
    end

    // register state and pin drive
    always_comb
    begin
        if (por_q == SOPLA_HOLD)
        begin
            state_d = `SOPLA_STATE_CLR;
        end
        else if (preload)
        begin
            // pin carries the inverse of state, so invert to match
            state_d = ~pin_in & REG_MASK;
        end
        else
        begin
            state_d = sums & REG_MASK;
        end
        for (int k = 0; k < `SOPLA_NUM_OUT; k++)
        begin
            if (REG_MASK[k])
            begin
                pins_d.level[k] = ~state_d[k];
                pins_d.oen[k]   = reg_oe_n;
            end
            else
            begin
                pins_d.level[k] = sums[k];
                pins_d.oen[k]   = ~enables[k];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state_q      <= `SOPLA_STATE_CLR;
            pins_q.level <= `SOPLA_ALL_OFF;
            pins_q.oen   <= `SOPLA_ALL_OFF;
        end
        else
        begin
            state_q <= state_d;
            pins_q  <= pins_d;
        end
    end

    // pattern readback, one cycle behind the address since the data comes from a flop
    always_comb
    begin
        if (secure)
        begin
            // all ones looks like a fully programmed array and hides the pattern
            rb_d = `SOPLA_SEC_ROW;
        end
        else
        begin
            rb_d = fuse_rows[rb_addr];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            rb_q <= `SOPLA_ROW_CLR;
        end
        else
        begin
            rb_q <= rb_d;
        end
    end

    assign pin_out = pins_q.level;
    assign pin_oen = pins_q.oen;
    assign rb_data = rb_q;

endmodule : sopla_top

// >>> tb/sopla_top_monitor.sv
`timescale 1ns/1ps

module sopla_top_monitor
    import sopla_pkg::*;
#(
    parameter int NUM_REG = 8
)
(
    // clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // pins and options
    input wire logic       reg_oe_n,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oen,
    input wire sopla_row_t fuse_rows [64],
    input wire logic       secure,
    input wire logic       preload,
    input wire logic [5:0] rb_addr,
    input wire sopla_row_t rb_data
);
    localparam logic [7:0] RM = (NUM_REG == 8) ? 8'hff : (NUM_REG == 6) ? 8'h7e : (NUM_REG == 4) ? 8'h3c : 8'h00;
    logic [4:0] hold_q;
    logic [4:0] hold_d;
    sopla_row_t rb_ref_q;
    sopla_row_t rb_ref_d;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // saturating count of edges since release, so the hold window is known
    always_comb
    begin
        hold_d   = (hold_q == 5'h1f) ? hold_q : hold_q + 5'h01;
        rb_ref_d = fuse_rows[rb_addr];
    end

    always_ff @(posedge clock)
    begin
        hold_q   <= rstn ? hold_d : 5'h00;
        rb_ref_q <= rb_ref_d;
    end

    sequence s_open;
        rstn && hold_q >= 5'h14;
    endsequence

    a_reset_pins: assert property (disable iff (1'b0) !rstn |=> pin_out == 8'hff && pin_oen == 8'hff)
        else $error("pins not idle after reset");
    a_hold_clear: assert property (rstn && hold_q < 5'h14 |=> (pin_out & RM) == RM)
        else $error("registered pin low during hold");
    a_oe_follow: assert property (rstn |=> (pin_oen & RM) == ({8{$past(reg_oe_n)}} & RM))
        else $error("registered enable does not follow pin");
    a_preload_load: assert property (s_open ##0 preload |=> (pin_out & RM) == ($past(pin_in) & RM))
        else $error("preload value not loaded");
    a_secure_blank: assert property (secure |=> rb_data == 32'hffff_ffff)
        else $error("secured readback shows pattern");
    a_readback_row: assert property (!secure |=> rb_data == rb_ref_q)
        else $error("readback row wrong");
    a_empty_enable: assert property (s_open ##0 (!RM[0] && fuse_rows[7] == 32'h0000_0000) |=> !pin_oen[0])
        else $error("empty enable term not driving");
    a_blocked_enable: assert property (s_open ##0 (!RM[0] && fuse_rows[7][1:0] == 2'b11) |=> pin_oen[0])
        else $error("blocked enable term driving");
endmodule : sopla_top_monitor

bind sopla_top sopla_top_monitor #(.NUM_REG(NUM_REG)) u_mon (.clock(clock), .rstn(rstn), .reg_oe_n(reg_oe_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oen(pin_oen), .fuse_rows(fuse_rows), .secure(secure),
    .preload(preload), .rb_addr(rb_addr), .rb_data(rb_data));

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
    import sopla_pkg::*;
    localparam logic [7:0] RM = 8'h3c;
    logic       clock, rstn, reg_oe_n, secure, preload, sum, en;
    logic [9:0] din;
    logic [7:0] pin_in, pin_out, pin_oen, ext, st, nst, eo, ee;
    logic [15:0] val;
    logic [5:0] rb_addr;
    sopla_row_t rb_data, er, lits;
    sopla_row_t fuse_rows [64];
    int fail_count = 0;
    int checks_done = 0;
    int edge_n = 0;

    // released pins show what the tester forces
    assign pin_in = (pin_out & ~pin_oen) | (ext & pin_oen);

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    sopla_top #(.NUM_REG(4)) DUT (.clock(clock), .rstn(rstn), .din(din), .reg_oe_n(reg_oe_n), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oen(pin_oen), .fuse_rows(fuse_rows), .secure(secure), .preload(preload),
        .rb_addr(rb_addr), .rb_data(rb_data));

    always @(posedge clock)
    begin
        edge_n = rstn ? edge_n + 1 : 0;
        val = {(RM & st) | (~RM & pin_in), din[7:0]};
        for (int i = 0; i < 16; i++)
        begin
            lits[2*i]   = val[i];
            lits[2*i+1] = ~val[i];
        end
        for (int k = 0; k < 8; k++)
        begin
            sum = 1'b0;
            for (int t = 0; t < 7; t++)
                sum = sum | (&(~fuse_rows[k*8+t] | lits));
            en = &(~fuse_rows[k*8+7] | lits);
            nst[k] = preload ? ~pin_in[k] : sum | en;
            eo[k] = sum;
            ee[k] = RM[k] ? reg_oe_n : ~en;
        end
        st = (edge_n > 20) ? nst & RM : 8'h00;
        eo = rstn ? (eo & ~RM) | (~st & RM) : 8'hff;
        ee = rstn ? ee : 8'hff;
        er = !rstn ? 32'h0000_0000 : secure ? 32'hffff_ffff : fuse_rows[rb_addr];
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    initial
    begin
        {rstn, reg_oe_n, secure, preload, din, ext, rb_addr} = '0;
        st = 8'h00;
        void'($urandom(80));
        foreach (fuse_rows[i])
            fuse_rows[i] = $urandom & $urandom & $urandom;
        for (int r = 0; r < 2; r++)
        begin
            for (int c = 0; c < 400; c++)
            begin
                @(negedge clock);
                if (r > 0 || c > 0)
                    check({16'h0000, pin_out, pin_oen}, {16'h0000, eo, ee});
                if (r > 0 || c > 0)
                    check(rb_data, er);
                rstn = (c >= 5);
                {din, ext, rb_addr} = 24'($urandom);
                reg_oe_n = 1'($urandom);
                secure = ($urandom % 4) == 0;
                preload = ($urandom % 4) == 0;
                fuse_rows[$urandom % 64] = $urandom & $urandom & $urandom;
                if (c % 8 == 0)
                    fuse_rows[7] = ($urandom % 2) ? 32'h0000_0000 : 32'h0000_0003;
            end
        end
        test_done;
    end
endmodule : tb
